// ---- src/cno_pkg.sv ----
// Purpose: shared constants for the node state control block
// Assumes: 250 MHz core clock, frame-level receive and transmit ports
// Notes: frame ids, codes, timing and slot numbers are named here; frame lengths and node id limits stay literal
package cno_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 250000; // 4 ns period
   localparam int HB_TIME_MS = 100; // heartbeat period
   localparam int PDO_TIME_MS = 10; // asynchronous pdo cycle
   localparam int HB_CYCLES = HB_TIME_MS * CLK_KHZ;
   localparam int PDO_CYCLES = PDO_TIME_MS * CLK_KHZ;

   // ------------------------------------------------------------
   // identity and defaults
   // ------------------------------------------------------------
   localparam logic [6:0] NODE_ID_DEFAULT = 7'h7F;
   localparam logic [31:0] LSS_VENDOR = 32'h00000ABC; // arbitrary
   localparam logic [31:0] LSS_PRODUCT = 32'h00000001; // arbitrary
   localparam logic [31:0] LSS_REVISION = 32'h00000001; // arbitrary

   // ------------------------------------------------------------
   // frame identifiers
   // ------------------------------------------------------------
   localparam logic [10:0] COB_NMT = 11'h000;
   localparam logic [10:0] COB_SYNC = 11'h080;
   localparam logic [10:0] COB_EMCY = 11'h080;
   localparam logic [10:0] COB_PDO1 = 11'h180;
   localparam logic [10:0] COB_PDO2 = 11'h280;
   localparam logic [10:0] COB_SDO_TX = 11'h580;
   localparam logic [10:0] COB_SDO_RX = 11'h600;
   localparam logic [10:0] COB_GUARD = 11'h700;
   localparam logic [10:0] COB_LSS_TX = 11'h7E4;
   localparam logic [10:0] COB_LSS_RX = 11'h7E5;

   // ------------------------------------------------------------
   // state byte encoding and commands
   // ------------------------------------------------------------
   localparam logic [7:0] SB_BOOT = 8'h00;
   localparam logic [7:0] SB_STOP = 8'h04;
   localparam logic [7:0] SB_OPER = 8'h05;
   localparam logic [7:0] SB_PREOP = 8'h7F;
   localparam logic [7:0] NMT_START = 8'h01;
   localparam logic [7:0] NMT_STOP = 8'h02;
   localparam logic [7:0] NMT_PREOP = 8'h80;
   localparam logic [7:0] NMT_RST_NODE = 8'h81;
   localparam logic [7:0] NMT_RST_COMM = 8'h82;
   localparam logic [7:0] LSS_SWITCH = 8'h04;
   localparam logic [7:0] LSS_SET_ID = 8'h11;
   localparam logic [7:0] LSS_SET_BR = 8'h13;
   localparam logic [7:0] LSS_STORE = 8'h17;
   localparam logic [7:0] SDO_UPLOAD = 8'h40;
   localparam logic [2:0] SDO_DNLOAD = 3'h1; // ccs field
   localparam logic [7:0] SDO_UP_RSP = 8'h43;
   localparam logic [7:0] SDO_ABORT = 8'h80;
   localparam logic [31:0] SDO_ABORT_RO = 32'h06010002;
   localparam logic [15:0] IDX_BOOT_COB = 16'h100E;
   localparam logic [7:0] EMCY_ERR_REG = 8'h01;

   // ------------------------------------------------------------
   // transmit slots, lowest index wins
   // ------------------------------------------------------------
   localparam int NSLOT = 8;
   localparam int SL_LSS = 0;
   localparam int SL_BOOT = 1;
   localparam int SL_GUARD = 2;
   localparam int SL_HB = 3;
   localparam int SL_SDO = 4;
   localparam int SL_EMCY = 5;
   localparam int SL_PDO1 = 6;
   localparam int SL_PDO2 = 7;

   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OPER, ST_STOP} cno_st_t;
endpackage

// ---- src/cno_tick.sv ----
// Purpose: free running period counter giving a one-cycle tick
// Assumes: run low holds the counter at zero
// Notes: period is a parameter so a bench can shorten it
module cno_tick #(
   parameter int CYCLES = 1000
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic run,
   output logic tick
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // count to the period and wrap
   always_comb
   begin
      cnt_nxt = cnt_r + 32'h00000001;
      tick_nxt = 1'b0;
      if (!run)
      begin
         cnt_nxt = 32'h00000000;
      end
      else if (cnt_r == 32'(CYCLES - 1))
      begin
         cnt_nxt = 32'h00000000;
         tick_nxt = 1'b1;
      end
   end

   // registers
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         cnt_r <= 32'h00000000;
         tick_r <= 1'b0;
      end
      else if (ce)
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule

// ---- src/cno_tx_arb.sv ----
// Purpose: fixed priority pick among pending transmit slots
// Assumes: slot 0 has the highest priority
// Notes: purely combinational
module cno_tx_arb (
   input wire logic [cno_pkg::NSLOT-1:0] req,
   output logic [cno_pkg::NSLOT-1:0] grant
);
   logic [cno_pkg::NSLOT:0] seen;

   // a slot wins when no lower slot asks
   assign seen[0] = 1'b0;
   genvar i;
   generate
      for (i = 0; i < cno_pkg::NSLOT; i++)
      begin : g_pri
         assign grant[i] = req[i] & ~seen[i];
         assign seen[i+1] = seen[i] | req[i];
      end
   endgenerate
endmodule

// ---- src/cno_node_ctrl.sv ----
// Purpose: network state machine and frame scheduler of an encoder node
// Assumes: frame-level rx/tx ports from a bus controller on core_clk
// Notes: one frame buffered for transmit, held until tx_ready
module cno_node_ctrl #(
   parameter int HB_CYCLES = cno_pkg::HB_CYCLES,
   parameter int PDO_CYCLES = cno_pkg::PDO_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic rx_rtr,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   input wire logic [3:0] bitrate_default,
   input wire logic [31:0] serial_number,
   input wire logic pdo_sync_mode,
   input wire logic [31:0] position,
   input wire logic [31:0] speed,
   input wire logic err_valid,
   input wire logic [15:0] err_code,
   output logic sdo_req_valid,
   output logic [63:0] sdo_req_data,
   input wire logic sdo_rsp_valid,
   input wire logic [63:0] sdo_rsp_data,
   output logic [1:0] node_state,
   output logic [6:0] node_id,
   output logic [3:0] bit_rate,
   output logic store_strobe,
   output logic [127:0] lss_address
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] state_code(cno_pkg::cno_st_t s);
      case (s)
         cno_pkg::ST_STOP: state_code = cno_pkg::SB_STOP;
         cno_pkg::ST_OPER: state_code = cno_pkg::SB_OPER;
         cno_pkg::ST_PREOP: state_code = cno_pkg::SB_PREOP;
         default: state_code = cno_pkg::SB_BOOT;
      endcase
   endfunction

   function automatic logic [10:0] cob(logic [10:0] base, logic [6:0] n);
      cob = base + {4'h0, n};
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cno_pkg::cno_st_t st_r, st_nxt;
   logic [7:0] pend_r, pend_nxt;
   logic toggle_r, toggle_nxt;
   logic [6:0] node_r, node_nxt, node_sv_r, node_sv_nxt;
   logic [3:0] br_r, br_nxt, br_sv_r, br_sv_nxt, br_pend_r, br_pend_nxt;
   logic br_loaded_r, br_loaded_nxt;
   logic lss_cfg_r, lss_cfg_nxt;
   logic [15:0] lss_rsp_r, lss_rsp_nxt;
   logic [63:0] sdo_rsp_r, sdo_rsp_nxt;
   logic [15:0] emcy_r, emcy_nxt;
   logic [31:0] pos_r, pos_nxt, spd_r, spd_nxt;
   logic txv_r, txv_nxt;
   logic [10:0] txid_r, txid_nxt;
   logic [3:0] txdlc_r, txdlc_nxt;
   logic [63:0] txd_r, txd_nxt;
   logic sdoq_r, sdoq_nxt;
   logic [63:0] sdoqd_r, sdoqd_nxt;
   logic store_r, store_nxt;
   logic [7:0] grant;
   logic hb_tick, pdo_tick, load;
   logic rx_nmt, rx_sync, rx_guard, rx_sdo, rx_lss, sdo_ok, is_100e;
   logic [7:0] b0, b1;
   logic [7:0] sc;

   // ------------------------------------------------------------
   // sub blocks
   // ------------------------------------------------------------
   cno_tick #(.CYCLES(HB_CYCLES)) u_hb (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .run(st_r != cno_pkg::ST_INIT),
      .tick(hb_tick)
   );

   cno_tick #(.CYCLES(PDO_CYCLES)) u_pdo (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .run(st_r == cno_pkg::ST_OPER && !pdo_sync_mode),
      .tick(pdo_tick)
   );

   cno_tx_arb u_arb (
      .req(pend_r),
      .grant(grant)
   );

   // ------------------------------------------------------------
   // receive decode
   // ------------------------------------------------------------
   assign b0 = rx_data[7:0];
   assign b1 = rx_data[15:8];
   assign sc = state_code(st_r);
   assign rx_nmt = rx_valid && !rx_rtr && rx_id == cno_pkg::COB_NMT
                   && (b1 == 8'h00 || b1 == {1'b0, node_r});
   assign rx_sync = rx_valid && !rx_rtr && rx_id == cno_pkg::COB_SYNC;
   assign rx_guard = rx_valid && rx_rtr
                     && rx_id == cob(cno_pkg::COB_GUARD, node_r);
   assign rx_sdo = rx_valid && !rx_rtr
                   && rx_id == cob(cno_pkg::COB_SDO_RX, node_r);
   assign rx_lss = rx_valid && !rx_rtr && rx_id == cno_pkg::COB_LSS_RX;
   assign sdo_ok = st_r == cno_pkg::ST_PREOP || st_r == cno_pkg::ST_OPER;
   assign is_100e = rx_data[23:8] == cno_pkg::IDX_BOOT_COB;
   assign load = !txv_r && |grant;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      pend_nxt = pend_r;
      toggle_nxt = toggle_r;
      node_nxt = node_r;
      node_sv_nxt = node_sv_r;
      br_nxt = br_r;
      br_sv_nxt = br_sv_r;
      br_pend_nxt = br_pend_r;
      br_loaded_nxt = br_loaded_r;
      lss_cfg_nxt = lss_cfg_r;
      lss_rsp_nxt = lss_rsp_r;
      sdo_rsp_nxt = sdo_rsp_r;
      emcy_nxt = emcy_r;
      pos_nxt = pos_r;
      spd_nxt = spd_r;
      txv_nxt = txv_r && !tx_ready;
      txid_nxt = txid_r;
      txdlc_nxt = txdlc_r;
      txd_nxt = txd_r;
      sdoq_nxt = 1'b0;
      sdoqd_nxt = sdoqd_r;
      store_nxt = 1'b0;
      // transmit slot load, clears the granted request first
      if (load)
      begin
         txv_nxt = 1'b1;
         txdlc_nxt = 4'h1;
         txd_nxt = 64'h0;
         txid_nxt = cob(cno_pkg::COB_GUARD, node_r);
         pend_nxt = pend_r & ~grant;
         if (grant[cno_pkg::SL_LSS])
         begin
            txid_nxt = cno_pkg::COB_LSS_TX;
            txdlc_nxt = 4'h8;
            txd_nxt = {48'h0, lss_rsp_r};
         end
         else if (grant[cno_pkg::SL_BOOT])
            txd_nxt = {56'h0, cno_pkg::SB_BOOT};
         else if (grant[cno_pkg::SL_GUARD])
         begin
            txd_nxt = {56'h0, toggle_r, sc[6:0]};
            toggle_nxt = !toggle_r;
         end
         else if (grant[cno_pkg::SL_HB])
            txd_nxt = {56'h0, sc};
         else if (grant[cno_pkg::SL_SDO])
         begin
            txid_nxt = cob(cno_pkg::COB_SDO_TX, node_r);
            txdlc_nxt = 4'h8;
            txd_nxt = sdo_rsp_r;
         end
         else if (grant[cno_pkg::SL_EMCY])
         begin
            txid_nxt = cob(cno_pkg::COB_EMCY, node_r);
            txdlc_nxt = 4'h8;
            txd_nxt = {40'h0, cno_pkg::EMCY_ERR_REG, emcy_r};
         end
         else if (grant[cno_pkg::SL_PDO1])
         begin
            txid_nxt = cob(cno_pkg::COB_PDO1, node_r);
            txdlc_nxt = 4'h4;
            txd_nxt = {32'h0, pos_r};
         end
         else
         begin
            txid_nxt = cob(cno_pkg::COB_PDO2, node_r);
            txdlc_nxt = 4'h4;
            txd_nxt = {32'h0, spd_r};
         end
      end
      // network state commands, obeyed in every state but init, where the move to preop wins
      if (rx_nmt)
      begin
         case (b0)
            cno_pkg::NMT_START: st_nxt = cno_pkg::ST_OPER;
            cno_pkg::NMT_STOP: st_nxt = cno_pkg::ST_STOP;
            cno_pkg::NMT_PREOP: st_nxt = cno_pkg::ST_PREOP;
            cno_pkg::NMT_RST_NODE:
            begin
               st_nxt = cno_pkg::ST_INIT;
               node_nxt = node_sv_r;
               br_nxt = br_sv_r;
            end
            cno_pkg::NMT_RST_COMM: st_nxt = cno_pkg::ST_INIT;
            default: st_nxt = st_r;
         endcase
      end
      // init: load the strap once, announce boot, go preop
      if (st_r == cno_pkg::ST_INIT)
      begin
         if (!br_loaded_r)
         begin
            br_sv_nxt = bitrate_default;
            br_nxt = bitrate_default;
            br_pend_nxt = bitrate_default;
            br_loaded_nxt = 1'b1;
         end
         pend_nxt = 8'h0;
         pend_nxt[cno_pkg::SL_BOOT] = 1'b1;
         toggle_nxt = 1'b0;
         st_nxt = cno_pkg::ST_PREOP;
      end
      // error control frames, kept in every running state
      if (rx_guard && st_r != cno_pkg::ST_INIT)
         pend_nxt[cno_pkg::SL_GUARD] = 1'b1;
      if (hb_tick && st_r != cno_pkg::ST_INIT)
         pend_nxt[cno_pkg::SL_HB] = 1'b1;
      // layer setting service, any state
      if (rx_lss)
      begin
         lss_rsp_nxt = {8'h00, b0};
         case (b0)
            cno_pkg::LSS_SWITCH: lss_cfg_nxt = b1[0];
            cno_pkg::LSS_SET_ID:
               if (lss_cfg_r)
               begin
                  if (b1 >= 8'h01 && b1 <= 8'h7F)
                     node_nxt = b1[6:0]; // effective at once
                  else
                     lss_rsp_nxt = {8'h01, b0};
                  pend_nxt[cno_pkg::SL_LSS] = 1'b1;
               end
            cno_pkg::LSS_SET_BR:
               if (lss_cfg_r)
               begin
                  br_pend_nxt = rx_data[19:16];
                  pend_nxt[cno_pkg::SL_LSS] = 1'b1;
               end
            cno_pkg::LSS_STORE:
               if (lss_cfg_r)
               begin
                  node_sv_nxt = node_r;
                  br_sv_nxt = br_pend_r; // rate takes effect on a reset node command
                  store_nxt = 1'b1;
                  pend_nxt[cno_pkg::SL_LSS] = 1'b1;
               end
            default: lss_rsp_nxt = lss_rsp_r;
         endcase
      end
      // service data: boot id object local, rest forwarded
      if (rx_sdo && sdo_ok)
      begin
         if (is_100e && b0 == cno_pkg::SDO_UPLOAD)
         begin
            sdo_rsp_nxt = {21'h0, cob(cno_pkg::COB_GUARD, node_r),
                           rx_data[31:8], cno_pkg::SDO_UP_RSP};
            pend_nxt[cno_pkg::SL_SDO] = 1'b1;
         end
         else if (is_100e && b0[7:5] == cno_pkg::SDO_DNLOAD)
         begin
            sdo_rsp_nxt = {cno_pkg::SDO_ABORT_RO, rx_data[31:8],
                           cno_pkg::SDO_ABORT};
            pend_nxt[cno_pkg::SL_SDO] = 1'b1;
         end
         else
         begin
            sdoq_nxt = 1'b1;
            sdoqd_nxt = rx_data;
         end
      end
      if (sdo_rsp_valid && sdo_ok)
      begin
         sdo_rsp_nxt = sdo_rsp_data;
         pend_nxt[cno_pkg::SL_SDO] = 1'b1;
      end
      // emergency and process data, operational only
      if (st_r == cno_pkg::ST_OPER)
      begin
         if (err_valid)
         begin
            emcy_nxt = err_code;
            pend_nxt[cno_pkg::SL_EMCY] = 1'b1;
         end
         if (pdo_sync_mode ? rx_sync : pdo_tick)
         begin
            pos_nxt = position;
            spd_nxt = speed;
            pend_nxt[cno_pkg::SL_PDO1] = 1'b1;
            pend_nxt[cno_pkg::SL_PDO2] = 1'b1;
         end
      end
      // drop what the new state may not send
      if (st_nxt != cno_pkg::ST_OPER)
         pend_nxt[7:5] = 3'h0;
      if (st_nxt == cno_pkg::ST_STOP)
         pend_nxt[cno_pkg::SL_SDO] = 1'b0;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st_r <= cno_pkg::ST_INIT;
         pend_r <= 8'h00;
         toggle_r <= 1'b0;
         node_r <= cno_pkg::NODE_ID_DEFAULT;
         node_sv_r <= cno_pkg::NODE_ID_DEFAULT;
         br_r <= 4'h0;
         br_sv_r <= 4'h0;
         br_pend_r <= 4'h0;
         br_loaded_r <= 1'b0;
         lss_cfg_r <= 1'b0;
         lss_rsp_r <= 16'h0000;
         sdo_rsp_r <= 64'h0;
         emcy_r <= 16'h0000;
         pos_r <= 32'h0;
         spd_r <= 32'h0;
         txv_r <= 1'b0;
         txid_r <= 11'h000;
         txdlc_r <= 4'h0;
         txd_r <= 64'h0;
         sdoq_r <= 1'b0;
         sdoqd_r <= 64'h0;
         store_r <= 1'b0;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         pend_r <= pend_nxt;
         toggle_r <= toggle_nxt;
         node_r <= node_nxt;
         node_sv_r <= node_sv_nxt;
         br_r <= br_nxt;
         br_sv_r <= br_sv_nxt;
         br_pend_r <= br_pend_nxt;
         br_loaded_r <= br_loaded_nxt;
         lss_cfg_r <= lss_cfg_nxt;
         lss_rsp_r <= lss_rsp_nxt;
         sdo_rsp_r <= sdo_rsp_nxt;
         emcy_r <= emcy_nxt;
         pos_r <= pos_nxt;
         spd_r <= spd_nxt;
         txv_r <= txv_nxt;
         txid_r <= txid_nxt;
         txdlc_r <= txdlc_nxt;
         txd_r <= txd_nxt;
         sdoq_r <= sdoq_nxt;
         sdoqd_r <= sdoqd_nxt;
         store_r <= store_nxt;
      end
   end

   // outputs
   assign tx_valid = txv_r;
   assign tx_id = txid_r;
   assign tx_dlc = txdlc_r;
   assign tx_data = txd_r;
   assign sdo_req_valid = sdoq_r;
   assign sdo_req_data = sdoqd_r;
   assign node_state = st_r;
   assign node_id = node_r;
   assign bit_rate = br_r;
   assign store_strobe = store_r;
   assign lss_address = {cno_pkg::LSS_VENDOR, cno_pkg::LSS_PRODUCT,
                         cno_pkg::LSS_REVISION, serial_number};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_in_init;
      ce && st_r == cno_pkg::ST_INIT;
   endsequence
   sequence s_boot_out;
      ce && load && grant[cno_pkg::SL_BOOT];
   endsequence

   property p_init_boot;
      @(posedge core_clk) disable iff (!resetn)
      s_in_init |=> st_r == cno_pkg::ST_PREOP && pend_r[cno_pkg::SL_BOOT];
   endproperty
   a_init_boot: assert property (p_init_boot)
      else $error("init did not reach preop with boot pending");

   property p_boot_frame;
      @(posedge core_clk) disable iff (!resetn)
      s_boot_out |=> txv_r && txdlc_r == 4'h1 && txd_r[7:0] == 8'h00;
   endproperty
   a_boot_frame: assert property (p_boot_frame)
      else $error("boot frame malformed");

   property p_pdo_oper;
      @(posedge core_clk) disable iff (!resetn)
      load && |grant[7:5] |-> st_r == cno_pkg::ST_OPER;
   endproperty
   a_pdo_oper: assert property (p_pdo_oper)
      else $error("pdo or emergency outside operational");

   property p_emcy_first;
      @(posedge core_clk) disable iff (!resetn)
      load && pend_r[cno_pkg::SL_EMCY] |-> !grant[6] && !grant[7];
   endproperty
   a_emcy_first: assert property (p_emcy_first)
      else $error("pdo sent ahead of emergency");

   property p_sdo_gate;
      @(posedge core_clk) disable iff (!resetn)
      ce && rx_sdo && !sdo_ok |=> !sdoq_r;
   endproperty
   a_sdo_gate: assert property (p_sdo_gate)
      else $error("sdo served in wrong state");

   property p_guard_reply;
      @(posedge core_clk) disable iff (!resetn)
      ce && rx_guard && st_r == cno_pkg::ST_STOP && !txv_r && pend_r == 8'h0
      |=> ce ##1 txv_r && txd_r[6:0] == cno_pkg::SB_STOP[6:0];
   endproperty
   a_guard_reply: assert property (p_guard_reply)
      else $error("guard request not answered");

   property p_toggle;
      @(posedge core_clk) disable iff (!resetn)
      ce && load && grant[cno_pkg::SL_GUARD] |=> toggle_r != $past(toggle_r);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("guard toggle did not flip");

   property p_start;
      @(posedge core_clk) disable iff (!resetn)
      ce && rx_nmt && b0 == cno_pkg::NMT_START |=> st_r == cno_pkg::ST_OPER;
   endproperty
   a_start: assert property (p_start)
      else $error("start command ignored");

   property p_default_id;
      @(posedge core_clk) $rose(resetn) |-> node_r == 7'h7F;
   endproperty
   a_default_id: assert property (p_default_id)
      else $error("node id not 127 after reset");
endmodule

// ---- sim/cno_master_model.sv ----
// Purpose: bus master model taking the node's frames
// Assumes: frame-level transmit port of the node
// Notes: slow mode stalls every other cycle
module cno_master_model (
   input wire logic core_clk,
   input wire logic slow,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [63:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] log_id [32];
   logic [31:0] log_dt [32];
   int n = 0;
   logic ph = 1'b0;
   // ready always or on alternate cycles
   assign tx_ready = !slow || ph;
   // log each frame taken at a handshake
   always @(posedge core_clk)
   begin
      ph <= !ph;
      if (tx_valid && tx_ready)
      begin
         log_id[n] <= tx_id;
         log_dt[n] <= tx_data[31:0];
         n <= n + 1;
      end
   end
endmodule

// ---- sim/test_canopen_node_state_control.sv ----
// Purpose: self-checking bench of the node state control
// Assumes: master model takes every frame the node sends
// Notes: one row per received frame, short timer periods
module test_canopen_node_state_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_rtr = 1'b0;
   logic err_valid = 1'b0;
   logic slow = 1'b0;
   logic ce = 1'b1;
   logic [10:0] rx_id = 11'h000;
   logic [63:0] rx_data = 64'h0;
   logic [31:0] pos = 32'h00561234;
   logic tx_valid;
   logic tx_ready;
   logic [10:0] tx_id;
   logic [63:0] tx_data;
   logic [1:0] node_state;
   logic [6:0] node_id;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   typedef struct {logic [10:0] id; logic rtr; logic err; logic [31:0] dt;
      int cnt; logic [10:0] eid; logic [31:0] edt; int st;} cno_row_t;
   // frame in, frame count, first frame out, state after
   cno_row_t rows [12] = '{
      '{11'h77F, 1, 0, 32'h0, 1, 11'h77F, 32'h7F, 1},
      '{11'h77F, 1, 0, 32'h0, 1, 11'h77F, 32'hFF, 1},
      '{11'h67F, 0, 0, 32'h00100E40, 1, 11'h5FF, 32'h00100E43, 1},
      '{11'h000, 0, 0, 32'h1, 0, 11'h0, 32'h0, 2},
      '{11'h080, 0, 0, 32'h0, 2, 11'h1FF, 32'h00561234, 2},
      '{11'h080, 0, 1, 32'h0, 3, 11'h0FF, 32'h00011234, 2},
      '{11'h000, 0, 0, 32'h2, 0, 11'h0, 32'h0, 3},
      '{11'h67F, 0, 0, 32'h00100E40, 0, 11'h0, 32'h0, 3},
      '{11'h77F, 1, 0, 32'h0, 1, 11'h77F, 32'h04, 3},
      '{11'h080, 0, 1, 32'h0, 0, 11'h0, 32'h0, 3},
      '{11'h000, 0, 0, 32'h80, 0, 11'h0, 32'h0, 1},
      '{11'h080, 0, 1, 32'h0, 0, 11'h0, 32'h0, 1}};
   cno_node_ctrl #(.HB_CYCLES(8000), .PDO_CYCLES(8000)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .ce(ce),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
      .rx_dlc(4'h8), .rx_data(rx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(), .tx_data(tx_data),
      .bitrate_default(4'h3), .serial_number(pos), .pdo_sync_mode(1'b1),
      .position(pos), .speed(~pos), .err_valid(err_valid),
      .err_code(pos[15:0]), .sdo_req_valid(), .sdo_req_data(),
      .sdo_rsp_valid(1'b0), .sdo_rsp_data(rx_data),
      .node_state(node_state), .node_id(node_id), .bit_rate(),
      .store_strobe(), .lss_address());
   cno_master_model u_mst (.core_clk(core_clk), .slow(slow),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
      .tx_data(tx_data));
   // compare and report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string nm);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic conclude;
      if (fails == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one received frame, then count replies and inspect the first
   task automatic send(input cno_row_t r, input logic s);
      int b;
      b = u_mst.n;
      slow <= s;
      rx_id <= r.id;
      rx_rtr <= r.rtr;
      rx_data <= {32'h0, r.dt};
      err_valid <= r.err;
      rx_valid <= 1'b1;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      err_valid <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk(32'(u_mst.n - b), 32'(r.cnt), "count");
      chk(32'(node_state), 32'(r.st), "state");
      if (r.cnt > 0)
      begin
         chk(32'(u_mst.log_id[b]), 32'(r.eid), "tx_id");
         chk(u_mst.log_dt[b], r.edt, "tx_data");
      end
   endtask
   // clock
   initial
   begin
      forever #2 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         fails++;
         conclude();
      end
   end
   // reset values, boot frame, then the table
   initial
   begin
      repeat (8) @(posedge core_clk);
      chk(32'(node_state), 32'h0, "reset state");
      chk(32'(node_id), 32'h7F, "reset id");
      chk(32'(tx_valid), 32'h0, "reset tx");
      resetn <= 1'b1;
      repeat (16) @(posedge core_clk);
      chk(32'(u_mst.n), 32'h1, "boot count");
      chk(32'(u_mst.log_id[0]), 32'h77F, "boot id");
      chk(u_mst.log_dt[0], 32'h0, "boot data");
      chk(32'(node_state), 32'h1, "boot state");
      foreach (rows[i])
         send(rows[i], i[0]);
      conclude();
   end
endmodule
